// *** include/dtc_defines.vh ***
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// ****************************************
// Register addresses in the special register space
// ****************************************
`define DTC_ADDR_TIMER_CONTROL 8'h88
`define DTC_ADDR_TIMER_MODE 8'h89
`define DTC_ADDR_TIMER_ZERO_LOW 8'h8A
`define DTC_ADDR_TIMER_ONE_LOW 8'h8B
`define DTC_ADDR_TIMER_ZERO_HIGH 8'h8C
`define DTC_ADDR_TIMER_ONE_HIGH 8'h8D
`define DTC_ADDR_CLOCK_CONTROL 8'h8E

// ****************************************
// Timer control bit positions
// ****************************************
`define DTC_TC_ONE_OVF 7
`define DTC_TC_ONE_RUN 6
`define DTC_TC_ZERO_OVF 5
`define DTC_TC_ZERO_RUN 4
`define DTC_TC_X1_FLAG 3
`define DTC_TC_X1_TYPE 2
`define DTC_TC_X0_FLAG 1
`define DTC_TC_X0_TYPE 0

// ****************************************
// Timer mode fields (per-timer nibble)
// ****************************************
`define DTC_TM_ONE_LSB 4
`define DTC_TM_ZERO_LSB 0
`define DTC_TM_GATE 3
`define DTC_TM_CT 2
`define DTC_MODE_13BIT 2'h0
`define DTC_MODE_16BIT 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

// ****************************************
// Clock control bit positions
// ****************************************
`define DTC_CK_ONE_SEL 4
`define DTC_CK_ZERO_SEL 3

// ****************************************
// Reset values and divider counts
// ****************************************
`define DTC_RST_ZERO 8'h00
`define DTC_RST_CLOCK_CONTROL 8'h01
`define DTC_RD_UNMAPPED 8'hFF
`define DTC_DIV_LAST 4'hB
`define DTC_DIV_FAST_MASK 2'h3

`endif

// *** verilog/dtc_timer_counter.v ***
`timescale 1ns/1ps
`include "dtc_defines.vh"
module dtc_timer_counter (
	// Clock and reset
	input wire clk_i,
	input wire nrst_i,
	// Special register access
	input wire [7:0] sfr_addr_i,
	input wire sfr_wr_i,
	input wire sfr_rd_i,
	input wire [7:0] sfr_wdata_i,
	output reg [7:0] sfr_rdata_o,
	// Vectoring acknowledges
	input wire timer_zero_vector_i,
	input wire timer_one_vector_i,
	input wire ext_irq_zero_vector_i,
	input wire ext_irq_one_vector_i,
	// Pins
	input wire timer_zero_count_pin_i,
	input wire timer_one_count_pin_i,
	input wire ext_irq_zero_pin_i,
	input wire ext_irq_one_pin_i,
	// Interrupt flags
	output reg timer_zero_overflow_flag_o,
	output reg timer_one_overflow_flag_o,
	output reg ext_irq_zero_flag_o,
	output reg ext_irq_one_flag_o
);

	// ****************************************
	// Step of one timer: {overflow, high, low}
	// ****************************************
	function [16:0] dtc_step;
		input [1:0] m;
		input [7:0] tl;
		input [7:0] th;
		input inc;
		reg [8:0] l;
		reg [8:0] h;
		begin
			l = {1'b0, tl} + 9'h001;
			h = {1'b0, th} + 9'h001;
			dtc_step = {1'b0, th, tl};
			if (inc) begin
				case (m)
					`DTC_MODE_13BIT: begin
						if (tl[4:0] == 5'h1F)
							dtc_step = {h[8], h[7:0], tl[7:5], 5'h00};
						else
							dtc_step = {1'b0, th, tl[7:5], l[4:0]};
					end
					`DTC_MODE_16BIT: begin
						if (&tl)
							dtc_step = {h[8], h[7:0], 8'h00};
						else
							dtc_step = {1'b0, th, l[7:0]};
					end
					`DTC_MODE_RELOAD: begin
						if (&tl)
							dtc_step = {1'b1, th, th};
						else
							dtc_step = {1'b0, th, l[7:0]};
					end
					default: dtc_step = {l[8], th, l[7:0]};
				endcase
			end
		end
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	reg [7:0] timer_control;
	reg [7:0] timer_mode;
	reg [7:0] timer_zero_low;
	reg [7:0] timer_zero_high;
	reg [7:0] timer_one_low;
	reg [7:0] timer_one_high;
	reg [7:0] clock_control;

	// ****************************************
	// Pin synchronisers and edge history
	// ****************************************
	reg [3:0] pin_s1;
	reg [3:0] pin_s2;
	reg [3:0] pin_s3;
	wire [3:0] pin_fall = pin_s3 & ~pin_s2;

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_s1 <= 4'hF;
			pin_s2 <= 4'hF;
			pin_s3 <= 4'hF;
		end else begin
			// Order: irq one, irq zero, count one, count zero
			pin_s1 <= {ext_irq_one_pin_i, ext_irq_zero_pin_i,
				timer_one_count_pin_i, timer_zero_count_pin_i};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end

	// ****************************************
	// Clock divider: one counter gives both rates
	// ****************************************
	reg [3:0] div_cnt;
	wire tick_slow = (div_cnt == `DTC_DIV_LAST);
	wire tick_fast = (div_cnt[1:0] == `DTC_DIV_FAST_MASK);

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			div_cnt <= 4'h0;
		else if (tick_slow)
			div_cnt <= 4'h0;
		else
			div_cnt <= div_cnt + 4'h1;
	end

	// ****************************************
	// Count enables
	// ****************************************
	wire [3:0] zero_cfg = timer_mode[`DTC_TM_ZERO_LSB +: 4];
	wire [3:0] one_cfg = timer_mode[`DTC_TM_ONE_LSB +: 4];
	wire [1:0] zero_mode = zero_cfg[1:0];
	wire [1:0] one_mode = one_cfg[1:0];
	wire zero_split = (zero_mode == `DTC_MODE_SPLIT);
	wire zero_tick = clock_control[`DTC_CK_ZERO_SEL] ? tick_fast : tick_slow;
	wire one_tick = clock_control[`DTC_CK_ONE_SEL] ? tick_fast : tick_slow;
	wire zero_run = timer_control[`DTC_TC_ZERO_RUN] &
		(~zero_cfg[`DTC_TM_GATE] | pin_s2[2]);
	wire one_run = timer_control[`DTC_TC_ONE_RUN] &
		(~one_cfg[`DTC_TM_GATE] | pin_s2[3]);
	wire zero_inc = zero_run & (zero_cfg[`DTC_TM_CT] ? pin_fall[0] : zero_tick);
	wire one_inc = one_run & (one_cfg[`DTC_TM_CT] ? pin_fall[1] : one_tick) &
		(one_mode != `DTC_MODE_SPLIT);
	// Split high byte: internal clock only, timer one run bit
	wire hi_zero_inc = zero_split & timer_control[`DTC_TC_ONE_RUN] & zero_tick;

	// ****************************************
	// Counter steps
	// ****************************************
	wire [16:0] zero_nxt = dtc_step(zero_mode, timer_zero_low, timer_zero_high, zero_inc);
	wire [16:0] one_nxt = dtc_step(one_mode, timer_one_low, timer_one_high, one_inc);
	wire [8:0] hi_zero_sum = {1'b0, timer_zero_high} + 9'h001;
	wire [7:0] next_hi_zero = zero_split ?
		(hi_zero_inc ? hi_zero_sum[7:0] : timer_zero_high) : zero_nxt[15:8];
	wire zero_ovf = zero_nxt[16];
	// In split mode timer one loses its flag to the high byte of timer zero
	wire one_ovf = zero_split ? (hi_zero_inc & hi_zero_sum[8]) : one_nxt[16];
	wire irq_zero_edge = timer_control[`DTC_TC_X0_TYPE] & pin_fall[2];
	wire irq_one_edge = timer_control[`DTC_TC_X1_TYPE] & pin_fall[3];

	// ****************************************
	// Register writes and flag updates
	// ****************************************
	wire wr_tc = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_TIMER_CONTROL);
	wire wr_tm = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_TIMER_MODE);
	wire wr_lo_zero = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_TIMER_ZERO_LOW);
	wire wr_lo_one = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_TIMER_ONE_LOW);
	wire wr_hi_zero = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_TIMER_ZERO_HIGH);
	wire wr_hi_one = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_TIMER_ONE_HIGH);
	wire wr_ck = sfr_wr_i & (sfr_addr_i == `DTC_ADDR_CLOCK_CONTROL);

	reg [7:0] next_tc;

	always @* begin
		next_tc = timer_control;
		if (wr_tc)
			next_tc = sfr_wdata_i;
		// Hardware vectoring clear, then set wins over any clear
		if (timer_one_vector_i)
			next_tc[`DTC_TC_ONE_OVF] = 1'b0;
		if (one_ovf)
			next_tc[`DTC_TC_ONE_OVF] = 1'b1;
		if (timer_zero_vector_i)
			next_tc[`DTC_TC_ZERO_OVF] = 1'b0;
		if (zero_ovf)
			next_tc[`DTC_TC_ZERO_OVF] = 1'b1;
		if (next_tc[`DTC_TC_X0_TYPE]) begin
			if (ext_irq_zero_vector_i)
				next_tc[`DTC_TC_X0_FLAG] = 1'b0;
			if (irq_zero_edge)
				next_tc[`DTC_TC_X0_FLAG] = 1'b1;
		end else begin
			next_tc[`DTC_TC_X0_FLAG] = ~pin_s2[2];
		end
		if (next_tc[`DTC_TC_X1_TYPE]) begin
			if (ext_irq_one_vector_i)
				next_tc[`DTC_TC_X1_FLAG] = 1'b0;
			if (irq_one_edge)
				next_tc[`DTC_TC_X1_FLAG] = 1'b1;
		end else begin
			next_tc[`DTC_TC_X1_FLAG] = ~pin_s2[3];
		end
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			timer_control <= `DTC_RST_ZERO;
			timer_mode <= `DTC_RST_ZERO;
			timer_zero_low <= `DTC_RST_ZERO;
			timer_zero_high <= `DTC_RST_ZERO;
			timer_one_low <= `DTC_RST_ZERO;
			timer_one_high <= `DTC_RST_ZERO;
			clock_control <= `DTC_RST_CLOCK_CONTROL;
			timer_zero_overflow_flag_o <= 1'b0;
			timer_one_overflow_flag_o <= 1'b0;
			ext_irq_zero_flag_o <= 1'b0;
			ext_irq_one_flag_o <= 1'b0;
		end else begin
			timer_control <= next_tc;
			timer_zero_overflow_flag_o <= next_tc[`DTC_TC_ZERO_OVF];
			timer_one_overflow_flag_o <= next_tc[`DTC_TC_ONE_OVF];
			ext_irq_zero_flag_o <= next_tc[`DTC_TC_X0_FLAG];
			ext_irq_one_flag_o <= next_tc[`DTC_TC_X1_FLAG];
			if (wr_tm)
				timer_mode <= sfr_wdata_i;
			if (wr_ck)
				clock_control <= sfr_wdata_i;
			// Software write to a count byte overrides that cycle's count
			timer_zero_low <= wr_lo_zero ? sfr_wdata_i : zero_nxt[7:0];
			timer_zero_high <= wr_hi_zero ? sfr_wdata_i : next_hi_zero;
			timer_one_low <= wr_lo_one ? sfr_wdata_i : one_nxt[7:0];
			timer_one_high <= wr_hi_one ? sfr_wdata_i : one_nxt[15:8];
		end
	end

	// ****************************************
	// Register reads
	// ****************************************
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sfr_rdata_o <= `DTC_RST_ZERO;
		end else if (sfr_rd_i) begin
			case (sfr_addr_i)
				`DTC_ADDR_TIMER_CONTROL: sfr_rdata_o <= timer_control;
				`DTC_ADDR_TIMER_MODE: sfr_rdata_o <= timer_mode;
				`DTC_ADDR_TIMER_ZERO_LOW: sfr_rdata_o <= timer_zero_low;
				`DTC_ADDR_TIMER_ONE_LOW: sfr_rdata_o <= timer_one_low;
				`DTC_ADDR_TIMER_ZERO_HIGH: sfr_rdata_o <= timer_zero_high;
				`DTC_ADDR_TIMER_ONE_HIGH: sfr_rdata_o <= timer_one_high;
				`DTC_ADDR_CLOCK_CONTROL: sfr_rdata_o <= clock_control;
				default: sfr_rdata_o <= `DTC_RD_UNMAPPED;
			endcase
		end
	end

endmodule

// *** verification/dtc_timer_counter_monitor.sv ***
`timescale 1ns/1ps
module dtc_timer_counter_monitor (
	// Clock, reset and register access
	input wire clk_i,
	input wire nrst_i,
	input wire [7:0] sfr_addr_i,
	input wire sfr_wr_i,
	input wire sfr_rd_i,
	input wire [7:0] sfr_wdata_i,
	input wire [7:0] sfr_rdata_o,
	// Vectors and pins
	input wire timer_zero_vector_i,
	input wire timer_one_vector_i,
	input wire ext_irq_zero_vector_i,
	input wire ext_irq_one_vector_i,
	input wire timer_zero_count_pin_i,
	input wire timer_one_count_pin_i,
	input wire ext_irq_zero_pin_i,
	input wire ext_irq_one_pin_i,
	// Flags
	input wire timer_zero_overflow_flag_o,
	input wire timer_one_overflow_flag_o,
	input wire ext_irq_zero_flag_o,
	input wire ext_irq_one_flag_o
);
	reg run0, run1, type0;
	wire tc_wr = sfr_wr_i && sfr_addr_i == 8'h88;
	// Shadow of both run bits and the interrupt zero trigger type bit
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			{run1, run0, type0} <= 3'h0;
		else if (tc_wr)
			{run1, run0, type0} <= {sfr_wdata_i[6], sfr_wdata_i[4], sfr_wdata_i[0]};
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	unmapped_read_a: assert property (
		sfr_rd_i && (sfr_addr_i < 8'h88 || sfr_addr_i > 8'h8e) |=> sfr_rdata_o == 8'hff)
		else $error("unmapped read not all ones");
	read_hold_a: assert property (
		!sfr_rd_i |=> $stable(sfr_rdata_o)) else $error("read data moved");
	zero_sw_set_a: assert property (
		tc_wr && sfr_wdata_i[5] && !timer_zero_vector_i |=> timer_zero_overflow_flag_o)
		else $error("timer zero flag set lost");
	one_sw_set_a: assert property (
		tc_wr && sfr_wdata_i[7] && !timer_one_vector_i |=> timer_one_overflow_flag_o)
		else $error("timer one flag set lost");
	one_idle_a: assert property (
		!run1 && !timer_one_overflow_flag_o && !tc_wr |=> !timer_one_overflow_flag_o)
		else $error("stopped timer one overflowed");
	zero_idle_a: assert property (
		!run0 && !timer_zero_overflow_flag_o && !tc_wr |=> !timer_zero_overflow_flag_o)
		else $error("stopped timer zero overflowed");
	zero_vector_a: assert property (
		timer_zero_vector_i && !run0 && !tc_wr |=> !timer_zero_overflow_flag_o)
		else $error("vector left timer zero flag set");
	level_low_a: assert property (
		(!type0 && !ext_irq_zero_pin_i)[*4] |-> ext_irq_zero_flag_o)
		else $error("level flag not following pin");
	edge_vector_a: assert property (
		(type0 && ext_irq_zero_pin_i && !tc_wr)[*5] ##0 ext_irq_zero_vector_i
		|=> !ext_irq_zero_flag_o) else $error("edge flag not cleared");
	cover property ($rose(timer_zero_overflow_flag_o));
	cover property ($rose(timer_one_overflow_flag_o));
	cover property ($rose(ext_irq_one_flag_o));
endmodule

bind dtc_timer_counter dtc_timer_counter_monitor mon_u (.*);

// *** verification/dtc_pin_model.sv ***
`timescale 1ns/1ps
module dtc_pin_model (
	// Clock
	input wire clk_i,
	// Count and interrupt pins
	output reg [1:0] cnt_pin_o,
	output reg [1:0] irq_pin_o
);
	// Port lines idle high
	initial begin
		cnt_pin_o = 2'h3;
		irq_pin_o = 2'h3;
	end
	// Falling edges, each level held at least two cycles for the synchronisers
	task pulse(input integer p, input integer n);
		repeat (n) begin
			@(negedge clk_i) cnt_pin_o[p] = 1'b0;
			repeat (2) @(negedge clk_i);
			cnt_pin_o[p] = 1'b1;
			repeat (2) @(negedge clk_i);
		end
	endtask
	task level(input integer p, input logic v);
		@(negedge clk_i) irq_pin_o[p] = v;
	endtask
endmodule

// *** verification/dtc_timer_counter_bench.sv ***
`timescale 1ns/1ps
module dtc_timer_counter_bench;
	reg clk_i = 1'b0;
	reg nrst_i = 1'b0;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg [7:0] addr = 8'h00;
	reg [7:0] wd = 8'h00;
	reg [3:0] vec = 4'h0;
	reg [7:0] r;
	wire [7:0] rdata;
	wire [1:0] cp;
	wire [1:0] ip;
	wire [3:0] fl;
	integer err_total = 0;
	integer checked = 0;
	integer cyc = 0;
	always #10 clk_i = ~clk_i;
	dtc_pin_model pins_u (.clk_i(clk_i), .cnt_pin_o(cp), .irq_pin_o(ip));
	dtc_timer_counter dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(addr),
		.sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdata),
		.timer_zero_vector_i(vec[0]), .timer_one_vector_i(vec[1]),
		.ext_irq_zero_vector_i(vec[2]), .ext_irq_one_vector_i(vec[3]),
		.timer_zero_count_pin_i(cp[0]), .timer_one_count_pin_i(cp[1]),
		.ext_irq_zero_pin_i(ip[0]), .ext_irq_one_pin_i(ip[1]),
		.timer_zero_overflow_flag_o(fl[0]), .timer_one_overflow_flag_o(fl[1]),
		.ext_irq_zero_flag_o(fl[2]), .ext_irq_one_flag_o(fl[3]));
	task final_report;
		$display("mismatches %0d of %0d checks", err_total, checked);
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task cmp(input [7:0] got, input [7:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			err_total = err_total + 1;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr_reg(input [7:0] a, input [7:0] d);
		@(negedge clk_i) {addr, wd, wr} = {a, d, 1'b1};
		@(negedge clk_i) wr = 1'b0;
	endtask
	task rd_reg(input [7:0] a);
		@(negedge clk_i) {addr, rd} = {a, 1'b1};
		@(negedge clk_i) rd = 1'b0;
		r = rdata;
	endtask
	task vec_pulse(input integer i);
		@(negedge clk_i) vec[i] = 1'b1;
		@(negedge clk_i) vec[i] = 1'b0;
	endtask
	task wait_flag(input integer i);
		integer n;
		n = 0;
		while (fl[i] !== 1'b1 && n < 200) @(negedge clk_i) n = n + 1;
		cmp({7'h0, fl[i]}, 8'h01);
	endtask
	task t_regs;
		integer a;
		for (a = 8'h87; a < 8'h90; a = a + 1) begin
			rd_reg(a[7:0]);
			cmp(r, a == 8'h8e ? 8'h01 : (a < 8'h88 || a > 8'h8e) ? 8'hff : 8'h00);
		end
		wr_reg(8'h88, 8'ha0);
		cmp({4'h0, fl}, 8'h03);
		vec_pulse(0);
		vec_pulse(1);
		cmp({4'h0, fl}, 8'h00);
	endtask
	task t_period(input logic s, input [7:0] ck, input [7:0] p);
		integer n;
		wr_reg(8'h89, s ? 8'h20 : 8'h02);
		wr_reg(8'h8e, ck);
		wr_reg(8'h8c + {7'h0, s}, 8'hfe);
		wr_reg(8'h8a + {7'h0, s}, 8'hfe);
		wr_reg(8'h88, s ? 8'h40 : 8'h10);
		wait_flag(s);
		vec[s] = 1'b1;
		n = 0;
		do begin
			@(negedge clk_i) vec[s] = 1'b0;
			n = n + 1;
		end while (!fl[s] && n < 100);
		cmp(n[7:0], p);
		wr_reg(8'h88, 8'h00);
		rd_reg(8'h8c + {7'h0, s});
		cmp(r, 8'hfe);
	endtask
	task t_prescale;
		wr_reg(8'h89, 8'h00);
		wr_reg(8'h8e, 8'h10);
		wr_reg(8'h8b, 8'hff);
		wr_reg(8'h8d, 8'hff);
		wr_reg(8'h88, 8'h40);
		wait_flag(1);
		wr_reg(8'h88, 8'h00);
		rd_reg(8'h8b);
		cmp(r, 8'he0);
		rd_reg(8'h8d);
		cmp(r, 8'h00);
	endtask
	task t_split;
		wr_reg(8'h89, 8'h33);
		wr_reg(8'h8e, 8'h08);
		wr_reg(8'h8b, 8'h55);
		wr_reg(8'h8c, 8'hff);
		wr_reg(8'h88, 8'h40);
		wait_flag(1);
		wr_reg(8'h88, 8'h00);
		cmp({7'h0, fl[0]}, 8'h00);
		rd_reg(8'h8b);
		cmp(r, 8'h55);
	endtask
	task t_gate;
		wr_reg(8'h89, 8'h5d);
		wr_reg(8'h8a, 8'h00);
		wr_reg(8'h8b, 8'h00);
		wr_reg(8'h8c, 8'h00);
		wr_reg(8'h88, 8'h50);
		pins_u.level(0, 1'b0);
		pins_u.pulse(0, 3);
		cmp({7'h0, fl[2]}, 8'h01);
		rd_reg(8'h8a);
		cmp(r, 8'h00);
		pins_u.level(0, 1'b1);
		pins_u.pulse(0, 3);
		rd_reg(8'h8a);
		cmp(r, 8'h03);
		pins_u.pulse(1, 2);
		rd_reg(8'h8b);
		cmp(r, 8'h02);
		wr_reg(8'h88, 8'h00);
	endtask
	task t_edge;
		integer i;
		wr_reg(8'h88, 8'h05);
		for (i = 0; i < 2; i = i + 1) begin
			pins_u.level(i, 1'b0);
			pins_u.level(i, 1'b1);
			repeat (6) @(negedge clk_i);
			cmp({7'h0, fl[2 + i]}, 8'h01);
			vec_pulse(2 + i);
			cmp({7'h0, fl[2 + i]}, 8'h00);
		end
	endtask
	initial begin
		repeat (10) @(negedge clk_i);
		nrst_i = 1'b1;
		t_regs;
		t_period(1'b0, 8'h08, 8'h08);
		t_period(1'b0, 8'h00, 8'h18);
		t_period(1'b1, 8'h10, 8'h08);
		t_prescale;
		t_split;
		t_gate;
		t_edge;
		final_report;
	end
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			err_total = err_total + 1;
			final_report;
		end
	end
endmodule
